// >>> core/rss_status_strobes.sv
/*
  Status and strobe logic of a positioning receiver toward its host:
  error, ready and position-valid flags, four qualified mark inputs,
  four programmable frequency outputs and the external reset input.
  Assumes firmware drives the status through the register port and all
  pins other than the marks are synchronous to i_sys_clk.
*/
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "rss_consts.svh"
// Behaviour
// [RULE1] The error output rests inactive and goes active (default high) in an error state.
// [RULE2] Each mark input fires on its leading edge only after a pulse longer than 150 ns.
// [RULE3] Mark inputs default to active low, with a per-input polarity set by software.
// [RULE4] Four frequency outputs, idle-high by default, run at a software-set frequency.
// [RULE5] The ready output goes high when the receiver can accept commands.
// [RULE6] The ready output stays low while booting and while a reset is in progress.
// [RULE7] A non-fatal error raises the error output and leaves ready asserted.
// [RULE8] Position-valid drops in the same cycle that the error output rises.
// [RULE9] A fatal error drops ready, error and position-valid together for the restart.
// [RULE10] Position-valid is high exactly while a valid solution is reported.
// [RULE11] The external reset is active low and held over 20 us resets the receiver.
// [RULE12] The host should hold the external reset low over 150 ms at power-up; the host model holds it low 4 cycles.
// [RULE13] Each mark input is synchronised and width-checked by a cycle counter.
// [RULE14] Each qualified mark and each error rise gives an event pulse for firmware.
module rss_status_strobes (
  // clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst,
  // host-facing pins
  input  wire logic                     i_ext_reset_n,
  input  wire logic [`RSS_NUM_CH-1:0]   i_mark_in,
  output logic                          o_error,
  output logic                          o_command_ready,
  output logic                          o_pos_valid,
  output logic [`RSS_NUM_CH-1:0]        o_freq_out,
  // register port
  input  wire rss_pkg::rss_addr_type    i_addr,
  input  wire rss_pkg::rss_word_type    i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output rss_pkg::rss_word_type         o_rdata,
  // firmware events
  output logic [`RSS_NUM_CH-1:0]        o_mark_evt,
  output logic                          o_err_evt,
  output logic                          o_irq
);

  // life cycle, firmware status and interrupt registers
  rss_pkg::rss_state_type       state_ff;
  rss_pkg::rss_state_type       nxt_state;
  logic [`RSS_CTRL_W-1:0]       ctrl_ff;
  logic [`RSS_CTRL_W-1:0]       nxt_ctrl;
  logic [`RSS_CFG_W-1:0]        cfg_ff;
  logic [`RSS_IRQ_W-1:0]        stat_ff;
  logic [`RSS_IRQ_W-1:0]        nxt_stat;
  logic [`RSS_IRQ_W-1:0]        mask_ff;
  logic [`RSS_IRQ_W-1:0]        irq_evt;

  // external reset width counter
  logic [`RSS_EXT_CNT_W-1:0]    ext_cnt_ff;
  logic [`RSS_EXT_CNT_W-1:0]    nxt_ext_cnt;

  // frequency accumulators and read path
  rss_pkg::rss_word_type        inc_ff [`RSS_NUM_CH];
  rss_pkg::rss_word_type        acc_ff [`RSS_NUM_CH];
  rss_pkg::rss_word_type        rd_mux;
  rss_pkg::rss_word_type        rdata_ff;

  // per-channel marks, selects and pins
  logic [`RSS_NUM_CH-1:0]       mark_pulse;
  logic [`RSS_NUM_CH-1:0]       wr_inc;
  logic [`RSS_NUM_CH-1:0]       inc_sel;
  logic [`RSS_NUM_CH-1:0]       freq_inv;
  logic [`RSS_NUM_CH-1:0]       freq_ff;
  logic [`RSS_NUM_CH-1:0]       mark_evt_ff;
  logic                         error_ff;
  logic                         ready_ff;
  logic                         pos_ff;
  logic                         err_on_ff;
  logic                         err_evt_ff;
  logic                         irq_ff;

  // decode and event wires
  logic                         wr_ctrl;
  logic                         wr_cfg;
  logic                         wr_stat;
  logic                         wr_mask;
  logic                         fatal_req;
  logic                         ext_hit;
  logic                         ext_rise;
  logic                         in_run;
  logic                         err_on;
  logic                         err_rise;
  logic                         ctrl_clr;
  logic                         rd_ctrl_sel;
  logic                         rd_cfg_sel;
  logic                         rd_stat_sel;
  logic                         rd_irq_sel;
  logic                         rd_mask_sel;
  logic                         err_level;
  logic                         pos_level;

  // write decode
  assign wr_ctrl   = i_wr && (i_addr == `RSS_OFS_CTRL);
  assign wr_cfg    = i_wr && (i_addr == `RSS_OFS_CFG);
  assign wr_stat   = i_wr && (i_addr == `RSS_OFS_IRQ_STAT);
  assign wr_mask   = i_wr && (i_addr == `RSS_OFS_IRQ_MASK);
  assign fatal_req = wr_ctrl && i_wdata[`RSS_CTRL_FATAL];

  // read decode
  assign rd_ctrl_sel = (i_addr == `RSS_OFS_CTRL);
  assign rd_cfg_sel  = (i_addr == `RSS_OFS_CFG);
  assign rd_stat_sel = (i_addr == `RSS_OFS_STAT);
  assign rd_irq_sel  = (i_addr == `RSS_OFS_IRQ_STAT);
  assign rd_mask_sel = (i_addr == `RSS_OFS_IRQ_MASK);

  // external reset width check
  assign ext_hit     = (ext_cnt_ff == `RSS_EXT_CNT_W'(`RSS_EXT_RST_CYC));
  assign ext_rise    = !i_ext_reset_n &&
                       (ext_cnt_ff == `RSS_EXT_CNT_W'(`RSS_EXT_RST_CYC - 1));
  assign nxt_ext_cnt = i_ext_reset_n ? '0 :
                       ext_hit ? ext_cnt_ff : ext_cnt_ff + `RSS_EXT_CNT_W'(1);

  // life-cycle state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      rss_pkg::rss_st_boot: begin
        if (ext_hit) begin
          nxt_state = rss_pkg::rss_st_hold;          // [RULE11]
        end else if (ctrl_ff[`RSS_CTRL_FW_RDY]) begin
          nxt_state = rss_pkg::rss_st_run;
        end
      end
      rss_pkg::rss_st_run: begin
        if (ext_hit) begin
          nxt_state = rss_pkg::rss_st_hold;          // [RULE11]
        end else if (fatal_req) begin
          nxt_state = rss_pkg::rss_st_boot;          // [RULE9]
        end
      end
      rss_pkg::rss_st_hold: begin
        if (i_ext_reset_n) begin
          nxt_state = rss_pkg::rss_st_boot;
        end
      end
      default: begin
        nxt_state = rss_pkg::rss_st_boot;
      end
    endcase
  end

  // firmware status bits, wiped by any restart
  assign ctrl_clr = ext_hit || fatal_req || (state_ff == rss_pkg::rss_st_hold);
  assign nxt_ctrl = ctrl_clr ? `RSS_CTRL_RST :
                    wr_ctrl  ? i_wdata[`RSS_CTRL_W-1:0] : ctrl_ff;

  // flag levels derived from state and firmware status
  assign in_run   = (state_ff == rss_pkg::rss_st_run);
  assign err_on   = in_run && ctrl_ff[`RSS_CTRL_ERR];  // [RULE7]
  assign err_rise = err_on && !err_on_ff;              // [RULE14]
  assign err_level = err_on ^ cfg_ff[`RSS_CFG_ERR_POL];  // [RULE1]
  assign pos_level = in_run && ctrl_ff[`RSS_CTRL_POS] &&
                     !ctrl_ff[`RSS_CTRL_ERR];           // [RULE8]
  assign freq_inv  = ~cfg_ff[`RSS_CFG_FREQ_LSB +: `RSS_NUM_CH]; // [RULE4]

  // interrupt events and sticky status, set beats clear
  assign irq_evt  = {fatal_req, ext_rise, err_rise, mark_evt_ff};
  assign nxt_stat = (stat_ff & ~(wr_stat ? i_wdata[`RSS_IRQ_W-1:0] : '0)) | irq_evt;

  // state, control and config registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff   <= rss_pkg::rss_st_boot;
      ctrl_ff    <= `RSS_CTRL_RST;
      cfg_ff     <= `RSS_CFG_RST;                   // [RULE3]
      ext_cnt_ff <= '0;
    end else begin
      state_ff   <= nxt_state;
      ctrl_ff    <= nxt_ctrl;
      ext_cnt_ff <= nxt_ext_cnt;                    // [RULE11]
      if (wr_cfg) begin
        cfg_ff <= i_wdata[`RSS_CFG_W-1:0];          // [RULE3]
      end
    end
  end

  // status pins, all from flip-flops
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      error_ff  <= 1'b0;
      ready_ff  <= 1'b0;
      pos_ff    <= 1'b0;
      err_on_ff <= 1'b0;
    end else begin
      error_ff  <= err_level;                         // [RULE1] [RULE9]
      ready_ff  <= in_run;                            // [RULE5] [RULE6] [RULE7]
      pos_ff    <= pos_level;                         // [RULE8] [RULE10]
      err_on_ff <= err_on;
    end
  end

  // mark qualifiers, one per input
  genvar g;
  generate
    for (g = 0; g < `RSS_NUM_CH; g++) begin : g_mark
      rss_mark_if mark_bus ();
      assign mark_bus.pin        = i_mark_in[g];
      assign mark_bus.active_low = ~cfg_ff[`RSS_CFG_MARK_LSB + g]; // [RULE3]
      assign mark_pulse[g]       = mark_bus.mark;
      assign inc_sel[g]          = (i_addr == `RSS_OFS_INC0 +
                                    8'(g) * `RSS_INC_STRIDE);
      assign wr_inc[g]           = i_wr && inc_sel[g];
      rss_mark_qual u_qual (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .mark_io   (mark_bus.qual)
      );
    end
  endgenerate

  // event pulses, sticky status and interrupt
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mark_evt_ff <= '0;
      err_evt_ff  <= 1'b0;
      stat_ff     <= `RSS_IRQ_RST;
      mask_ff     <= `RSS_IRQ_RST;
      irq_ff      <= 1'b0;
    end else begin
      mark_evt_ff <= mark_pulse;   // [RULE14]
      err_evt_ff  <= err_rise;     // [RULE14]
      stat_ff     <= nxt_stat;
      irq_ff      <= |(stat_ff & mask_ff);
      if (wr_mask) begin
        mask_ff <= i_wdata[`RSS_IRQ_W-1:0];
      end
    end
  end

  // phase accumulators for the frequency outputs, idle when not running
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < `RSS_NUM_CH; k++) begin
        inc_ff[k] <= `RSS_INC_RST;
        acc_ff[k] <= `RSS_INC_RST;
      end
      freq_ff <= '1;
    end else begin
      for (int k = 0; k < `RSS_NUM_CH; k++) begin
        if (wr_inc[k]) begin
          inc_ff[k] <= i_wdata;                             // [RULE4]
        end
        acc_ff[k]  <= in_run ? acc_ff[k] + inc_ff[k] : `RSS_INC_RST;
        freq_ff[k] <= acc_ff[k][31] ^ freq_inv[k]; // [RULE4]
      end
    end
  end

  // read selection
  always_comb begin
    rd_mux = '0;
    if (rd_ctrl_sel) begin
      rd_mux = 32'(ctrl_ff);
    end else if (rd_cfg_sel) begin
      rd_mux = 32'(cfg_ff);
    end else if (rd_stat_sel) begin
      rd_mux = 32'({pos_ff, error_ff, ready_ff, state_ff});
    end else if (rd_irq_sel) begin
      rd_mux = 32'(stat_ff);
    end else if (rd_mask_sel) begin
      rd_mux = 32'(mask_ff);
    end else begin
      for (int k = 0; k < `RSS_NUM_CH; k++) begin
        if (inc_sel[k]) begin
          rd_mux = inc_ff[k];
        end
      end
    end
  end

  // read data stands for one cycle only
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= i_rd ? rd_mux : '0;
    end
  end

  // outputs
  assign o_error         = error_ff;
  assign o_command_ready = ready_ff;
  assign o_pos_valid     = pos_ff;
  assign o_freq_out      = freq_ff;
  assign o_rdata         = rdata_ff;
  assign o_mark_evt      = mark_evt_ff;
  assign o_err_evt       = err_evt_ff;
  assign o_irq           = irq_ff;

endmodule // rss_status_strobes

// >>> core/rss_consts.svh
/*
  Constants of the receiver status and strobe block: timing, register
  offsets, field positions and reset values.
  Assumes a 10 MHz system clock and an 8-bit register address.
*/
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// clock and timing
`define RSS_CLK_PERIOD_NS  100
`define RSS_MARK_MIN_NS    150
`define RSS_MARK_CYC       ((`RSS_MARK_MIN_NS + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS)
`define RSS_MARK_CNT_W     3
`define RSS_EXT_RST_MIN_US 20
`define RSS_EXT_RST_CYC    ((`RSS_EXT_RST_MIN_US * 1000 + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS)
`define RSS_EXT_CNT_W      8

// register offsets (byte addresses)
`define RSS_OFS_CTRL       8'h00
`define RSS_OFS_CFG        8'h04
`define RSS_OFS_STAT       8'h08
`define RSS_OFS_IRQ_STAT   8'h0c
`define RSS_OFS_IRQ_MASK   8'h10
`define RSS_OFS_INC0       8'h14
`define RSS_INC_STRIDE     8'h04

// control fields
`define RSS_CTRL_W         3
`define RSS_CTRL_FW_RDY    0
`define RSS_CTRL_ERR       1
`define RSS_CTRL_POS       2
`define RSS_CTRL_FATAL     3
`define RSS_CTRL_RST       3'h0

// config fields: mark polarity [3:0], freq polarity [7:4], error polarity
`define RSS_CFG_W          9
`define RSS_CFG_MARK_LSB   0
`define RSS_CFG_FREQ_LSB   4
`define RSS_CFG_ERR_POL    8
`define RSS_CFG_RST        9'h000

// interrupt status fields
`define RSS_IRQ_W          7
`define RSS_IRQ_ERR        4
`define RSS_IRQ_EXT        5
`define RSS_IRQ_FATAL      6
`define RSS_IRQ_RST        7'h00

// count of channels and the increment reset value
`define RSS_NUM_CH         4
`define RSS_INC_RST        32'h0000_0000

`endif

// >>> core/rss_pkg.sv
/*
  Types of the receiver status and strobe block.
  Assumes nothing beyond a SystemVerilog tool.
*/
package rss_pkg;

  // receiver life cycle
  typedef enum logic [1:0] {
    rss_st_boot = 2'b00,
    rss_st_run  = 2'b01,
    rss_st_hold = 2'b10
  } rss_state_type;

  typedef logic [31:0] rss_word_type;
  typedef logic [7:0]  rss_addr_type;

endpackage

// >>> core/rss_mark_if.sv
/*
  Carrier between the top and one mark qualifier: pin, polarity, mark pulse.
  Assumes the pin may be asynchronous to i_sys_clk; the qualifier synchronises it.
*/
`timescale 1ns/1ps
interface rss_mark_if;
  logic pin;
  logic active_low;
  logic mark;

  modport qual (input pin, input active_low, output mark);
  modport top  (output pin, output active_low, input mark);
endinterface

// >>> core/rss_mark_qual.sv
/*
  One event-mark qualifier: synchroniser, polarity, width counter, pulse.
  Assumes one system clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_mark_qual (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  // mark carrier
  rss_mark_if.qual  mark_io
);

  logic                       sync1_ff;
  logic                       sync2_ff;
  logic                       armed_ff;
  logic                       mark_ff;
  logic [`RSS_MARK_CNT_W-1:0] cnt_ff;
  logic [`RSS_MARK_CNT_W-1:0] nxt_cnt;
  logic                       asserted;
  logic                       qualify;

  // polarity and width qualification
  assign asserted = sync2_ff ^ mark_io.active_low;
  assign qualify  = asserted && armed_ff &&
                    (cnt_ff == `RSS_MARK_CNT_W'(`RSS_MARK_CYC - 1));
  assign nxt_cnt  = (!asserted || !armed_ff) ? '0 :
                    (cnt_ff == `RSS_MARK_CNT_W'(`RSS_MARK_CYC)) ? cnt_ff :
                    cnt_ff + `RSS_MARK_CNT_W'(1);
  assign mark_io.mark = mark_ff;

  // two-stage synchroniser
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= mark_io.pin;  // [RULE13]
      sync2_ff <= sync1_ff;
    end
  end

  // width counter, one pulse per leading edge
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff   <= '0;
      armed_ff <= 1'b0;
      mark_ff  <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;              // [RULE13]
      armed_ff <= armed_ff | ~asserted; // [RULE2]
      mark_ff  <= qualify;              // [RULE2]
    end
  end

endmodule // rss_mark_qual

// >>> dv/rss_ss_asserts.sv
/* port checker of the status strobe block
   assumes a bind onto rss_status_strobes */
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_ss_asserts (
  // clock and reset
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst,
  // watched ports
  input wire logic                   i_ext_reset_n,
  input wire logic [`RSS_NUM_CH-1:0] i_mark_in,
  input wire logic                   i_rd,
  input wire logic                   o_error,
  input wire logic                   o_command_ready,
  input wire logic                   o_pos_valid,
  input wire logic [`RSS_NUM_CH-1:0] o_freq_out,
  input wire rss_pkg::rss_word_type  o_rdata,
  input wire logic [`RSS_NUM_CH-1:0] o_mark_evt,
  input wire logic                   o_err_evt
);
  logic [7:0] low_cnt_ff;
  wire  [7:0] nxt_low_cnt = i_ext_reset_n ? 8'h00 : low_cnt_ff + {7'h00, low_cnt_ff != 8'hff};
  // cycles the external reset pin has stayed low
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst) low_cnt_ff <= 8'h00;
    else low_cnt_ff <= nxt_low_cnt;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_pos_drop; $rose(o_error) |-> !o_pos_valid; endproperty
  a_pos_drop: assert property (p_pos_drop) else $error("pos valid high at error rise");
  property p_err_rdy; $rose(o_error) |-> o_command_ready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("ready low at error rise");
  property p_pos_run; o_pos_valid |-> o_command_ready && !o_error; endproperty
  a_pos_run: assert property (p_pos_run) else $error("pos valid out of run");
  property p_fall_all; $fell(o_command_ready) |-> !o_error && !o_pos_valid; endproperty
  a_fall_all: assert property (p_fall_all) else $error("flags not low together");
  property p_rdy_ext; $rose(o_command_ready) |-> $past(i_ext_reset_n); endproperty
  a_rdy_ext: assert property (p_rdy_ext) else $error("ready rose in reset");
  property p_ext_hold; low_cnt_ff > 8'hca |-> !o_command_ready; endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("ready high in long reset");
  property p_err_evt; 1'b1 |-> (o_err_evt == $rose(o_error)); endproperty
  a_err_evt: assert property (p_err_evt) else $error("error event mismatch");
  property p_mark_w;
    |o_mark_evt |-> ((($past(i_mark_in, 4) ^ $past(i_mark_in, 5)) & o_mark_evt) == 4'h0);
  endproperty
  a_mark_w: assert property (p_mark_w) else $error("mark from short pulse");
  property p_mark_one; (o_mark_evt & $past(o_mark_evt)) == 4'h0; endproperty
  a_mark_one: assert property (p_mark_one) else $error("mark event too long");
  property p_freq_idle;
    !o_command_ready && !$past(o_command_ready) && !$past(o_command_ready, 2)
      |-> o_freq_out == 4'hf;
  endproperty
  a_freq_idle: assert property (p_freq_idle) else $error("freq output active off run");
  property p_rdata; o_rdata != 32'h0 |-> $past(i_rd); endproperty
  a_rdata: assert property (p_rdata) else $error("read data without read");
  c_mark: cover property (|o_mark_evt);
  c_err: cover property ($rose(o_error));
  c_down: cover property ($fell(o_command_ready));
endmodule // rss_ss_asserts

bind rss_status_strobes rss_ss_asserts u_chk (.i_sys_clk, .i_rst, .i_ext_reset_n, .i_mark_in,
  .i_rd, .o_error, .o_command_ready, .o_pos_valid, .o_freq_out, .o_rdata, .o_mark_evt, .o_err_evt);

// >>> dv/rss_host_model.sv
/* host model: drives the mark pins and the external reset pin
   assumes the bench clock and a bench that calls its tasks */
`timescale 1ns/1ps
module rss_host_model (
  // clock
  input  wire logic i_sys_clk,
  // pins toward the receiver
  output logic [3:0] o_mark_in,
  output logic       o_ext_reset_n
);
  // pins idle; reset pin low at power-up, then released
  initial begin
    o_mark_in = 4'hf;
    o_ext_reset_n = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    o_ext_reset_n <= 1'b1;
  end
  // pulse of n samples at level lvl, then idle again
  task automatic pulse(input int ch, input logic lvl, input int n);
    @(posedge i_sys_clk) o_mark_in[ch] <= lvl;
    repeat (n) @(posedge i_sys_clk);
    o_mark_in[ch] <= ~lvl;
    repeat (4) @(posedge i_sys_clk);
  endtask
  task automatic set_all(input logic [3:0] v);
    @(posedge i_sys_clk) o_mark_in <= v;
  endtask
  // reset pin low for n samples
  task automatic ext_low(input int n);
    @(posedge i_sys_clk) o_ext_reset_n <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
    o_ext_reset_n <= 1'b1;
  endtask
endmodule // rss_host_model

// >>> dv/tb_rss_status_strobes.sv
/* self-checking bench of the status strobe block
   assumes the host model and the bound checker */
`timescale 1ns/1ps
module tb_rss_status_strobes;
  logic                  i_sys_clk = 1'b0;
  logic                  i_rst     = 1'b1;
  logic                  i_wr      = 1'b0;
  logic                  i_rd      = 1'b0;
  rss_pkg::rss_addr_type i_addr    = 8'h00;
  rss_pkg::rss_word_type i_wdata   = 32'h0;
  rss_pkg::rss_word_type o_rdata, rd_q, inc;
  logic                  ext_n, o_error, o_rdy, o_pos, o_err_evt, o_irq;
  logic [3:0]            mark_pin, o_freq, o_mevt;
  logic                  freq_q = 1'b1;
  int                    errors = 0, check_count = 0, seed = 87, mark_cnt = 0, tog = 0, c0;

  always #50 i_sys_clk = ~i_sys_clk;

  rss_host_model u_host (.i_sys_clk(i_sys_clk), .o_mark_in(mark_pin), .o_ext_reset_n(ext_n));
  rss_status_strobes u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ext_reset_n(ext_n),
    .i_mark_in(mark_pin), .o_error(o_error), .o_command_ready(o_rdy), .o_pos_valid(o_pos),
    .o_freq_out(o_freq), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_mark_evt(o_mevt), .o_err_evt(o_err_evt), .o_irq(o_irq));

  // counts of mark pulses and of toggles on the first frequency output
  always @(posedge i_sys_clk) begin
    mark_cnt <= mark_cnt + $countones(o_mevt);
    freq_q <= o_freq[0];
    tog <= tog + int'(freq_q != o_freq[0]);
  end

  function automatic logic [31:0] exp_mark(input int n);
    return (n >= 2) ? 32'h1 : 32'h0;
  endfunction
  function automatic int exp_tog(input logic [31:0] f, input int n);
    return int'((longint'(f) * n) >>> 31);
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input rss_pkg::rss_addr_type a, input rss_pkg::rss_word_type d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input rss_pkg::rss_addr_type a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 rd_q = o_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic mark_try(input logic lvl);
    int ch, n, m0;
    ch = int'($unsigned($random(seed)) % 4);
    n = 1 + int'($unsigned($random(seed)) % 4);
    m0 = mark_cnt;
    u_host.pulse(ch, lvl, n);
    cyc(4);
    chk("mark", exp_mark(n), mark_cnt - m0);
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    errors++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    cyc(1);
    chk("rst pins", 32'h000f, {o_rdy, o_error, o_pos, o_irq, o_err_evt, o_mevt, o_freq});
    rd(8'h04);
    chk("cfg", 32'h0, rd_q);
    wr(8'h00, 32'h1);
    cyc(1);
    chk("ready early", 32'h0, o_rdy);
    cyc(1);
    chk("ready", 32'h1, o_rdy);
    rd(8'h08);
    chk("stat", 32'h5, rd_q);
    wr(8'h00, 32'h5);
    cyc(2);
    chk("pos", 32'h1, o_pos);
    wr(8'h00, 32'h7);
    cyc(1);
    chk("err", 32'hb, {o_error, o_pos, o_rdy, o_err_evt});
    cyc(1);
    chk("err evt", 32'h0, o_err_evt);
    rd(8'h0c);
    chk("irq stat", 32'h10, rd_q & 32'h10);
    wr(8'h10, 32'h10);
    cyc(2);
    chk("irq", 32'h1, o_irq);
    wr(8'h0c, 32'h10);
    cyc(2);
    chk("irq clr", 32'h0, o_irq);
    rd(8'h40);
    chk("unmapped", 32'h0, rd_q);
    $display("test status done");
    repeat (8) mark_try(1'b0);
    c0 = mark_cnt;
    u_host.set_all(4'h0);
    cyc(8);
    chk("all marks", 32'h4, mark_cnt - c0);
    wr(8'h04, 32'h0f);
    repeat (8) mark_try(1'b1);
    rd(8'h0c);
    chk("mark irq", 32'hf, rd_q & 32'hf);
    $display("test marks done");
    inc = 32'h0400_0000 * (1 + ($unsigned($random(seed)) % 16));
    wr(8'h14, inc);
    wr(8'h18, 32'h0);
    cyc(4);
    c0 = tog;
    cyc(40);
    c0 = tog - c0 - exp_tog(inc, 40);
    chk("freq", 32'h1, (c0 >= -1 && c0 <= 1));
    chk("freq idle", 32'h1, o_freq[1]);
    wr(8'h00, 32'h8);
    cyc(2);
    chk("fatal", 32'h0, {o_rdy, o_error, o_pos});
    cyc(2);
    chk("fatal freq", 32'hf, o_freq);
    rd(8'h0c);
    chk("fatal irq", 32'h40, rd_q & 32'h40);
    $display("test freq done");
    wr(8'h00, 32'h1);
    cyc(2);
    u_host.ext_low(100);
    cyc(2);
    chk("short ext", 32'h1, o_rdy);
    u_host.ext_low(210);
    cyc(1);
    chk("long ext", 32'h0, o_rdy);
    rd(8'h0c);
    chk("ext irq", 32'h20, rd_q & 32'h20);
    $display("test reset done");
    end_of_test();
  end
endmodule // tb_rss_status_strobes
